// [common/lcv_pkg.sv]
// ----------------------------------------------------------------
// Shared constants for the light conversion block
// ----------------------------------------------------------------
package lcv_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    // System clock rate in hertz
    localparam int unsigned CLK_HZ = 50_000_000;
    // Integration step time in microseconds
    localparam int unsigned STEP_TIME_US = 2700;
    // Step length in clock cycles, derived from the two above
    localparam int unsigned STEP_CYC = (CLK_HZ / 1_000_000) * STEP_TIME_US;
    // Highest host bit rate in kbit/s, for reference by the bridge
    localparam int unsigned BUS_MAX_KBPS = 400;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int RES_W = 16;
    localparam int ACC_W = 24;
    localparam int GAIN_W = 7;
    localparam int STS_W = 2;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ITIME = 8'h04;
    localparam logic [7:0] OFS_THR_LO = 8'h08;
    localparam logic [7:0] OFS_THR_HI = 8'h0C;
    localparam logic [7:0] OFS_PERS = 8'h10;
    localparam logic [7:0] OFS_BB = 8'h14;
    localparam logic [7:0] OFS_IR = 8'h18;
    localparam logic [7:0] OFS_BOTH = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_MASK = 8'h24;
    localparam logic [7:0] OFS_INT_CLR = 8'h28;
    localparam logic [7:0] OFS_TADDR = 8'h2C;
    localparam logic [7:0] OFS_INFO = 8'h30;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_GAIN_LSB = 1;
    localparam int STS_THR_BIT = 0;
    localparam int STS_DONE_BIT = 1;
    localparam int INFO_PEND_BIT = 0;
    localparam int INFO_RUN_BIT = 1;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [7:0] ITIME_RST = 8'hFF;
    localparam logic [15:0] THR_LO_RST = 16'h0000;
    localparam logic [15:0] THR_HI_RST = 16'hFFFF;
    localparam logic [3:0] PERS_RST = 4'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    // Steps in a cycle are this figure minus the programmed count
    localparam logic [8:0] STEPS_FULL = 9'h100;
    localparam logic [15:0] RES_MAX = 16'hFFFF;

    // ----------------------------------------------------------------
    // Gain codes and their multipliers
    // ----------------------------------------------------------------
    localparam logic [1:0] GAIN_1X = 2'h0;
    localparam logic [1:0] GAIN_8X = 2'h1;
    localparam logic [1:0] GAIN_16X = 2'h2;
    localparam logic [GAIN_W-1:0] MUL_1X = 7'h01;
    localparam logic [GAIN_W-1:0] MUL_8X = 7'h08;
    localparam logic [GAIN_W-1:0] MUL_16X = 7'h10;
    localparam logic [GAIN_W-1:0] MUL_111X = 7'h6F;

    // ----------------------------------------------------------------
    // Address select levels and target addresses
    // ----------------------------------------------------------------
    localparam logic [1:0] ASEL_GND = 2'h0;
    localparam logic [1:0] ASEL_FLOAT = 2'h1;
    localparam logic [6:0] TADDR_GND = 7'h29;
    localparam logic [6:0] TADDR_FLOAT = 7'h39;
    localparam logic [6:0] TADDR_VDD = 7'h49;

    // Conversion sequencer, Gray coded along idle, integrate, transfer
    typedef enum logic [1:0] {
        LCV_IDLE = 2'b00,
        LCV_INTEG = 2'b01,
        LCV_XFER = 2'b11
    } lcv_state_t;

endpackage

// [common/lcv_thr_if.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Result and window limits to the threshold comparator
// ----------------------------------------------------------------
interface lcv_thr_if;
    // Fresh conversion result
    logic [15:0] result;
    // Lower and upper window limits
    logic [15:0] lo;
    logic [15:0] hi;
    // Result is new this cycle
    logic valid;
    // Result lies outside the window
    logic outside;

    modport src
    (
        output result, lo, hi, valid,
        input outside
    );
    modport chk
    (
        input result, lo, hi, valid,
        output outside
    );
endinterface

// [hdl/lcv_window_check.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Window comparator for one channel result
// ----------------------------------------------------------------
module lcv_window_check
(
    lcv_thr_if.chk thr
);
    // Outside when strictly above upper or strictly below lower
    always_comb
    begin
        thr.outside = thr.valid && ((thr.result > thr.hi) || (thr.result < thr.lo));
    end
endmodule

// [hdl/lcv_top.sv]
`timescale 1ns/1ps
// Summary of operation
// [R1] Both channels integrate together, same start/end
// [R2] Cycle end loads each channel's data register
// [R3] Results double-buffered, never mixed old/new
// [R4] Next integration starts automatically while enabled
// [R5] Programmable upper and lower thresholds held
// [R6] Result outside window flags interrupt condition
// [R7] Persistence count of consecutive excursions qualifies
// [R8] Interrupt holds as level until firmware clears
// [R9] Open-drain interrupt pin pulls low when pending
// [R10] Host bus target, up to 400 kbit/s
// [R11] Gain and integration time apply to both
// [R12] Three-level address pin chooses target address
// [R13] Ground 0x29, float 0x39, supply 0x49
// [R14] Integration time is count of 2.7 ms steps
// [R15] Clear write releases pin, re-arms persistence
module lcv_top
#(
    // Cycles per integration step; shorten for simulation
    parameter int unsigned STEP_CYCLES = lcv_pkg::STEP_CYC
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic [1:0] i_addr_sel,
    input wire logic [15:0] i_bb_level,
    input wire logic [15:0] i_ir_level,
    output logic o_integrating,
    output logic o_int_n_o,
    output logic o_int_n_oe,
    output logic o_irq
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam int DIV_W = $clog2(STEP_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_CYCLES - 1);

    // Bus and register group
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [2:0] ctrl_q, ctrl_d;
    logic [7:0] itime_q, itime_d;
    logic [15:0] lo_q, lo_d;
    logic [15:0] hi_q, hi_d;
    logic [3:0] pers_q, pers_d;
    logic [1:0] mask_q, mask_d;
    logic [1:0] sts_q, sts_d;
    logic irq_q, irq_d;
    logic [6:0] taddr_q, taddr_d;
    logic strap_q, strap_d;
    logic clr_pulse;
    // Conversion group
    lcv_pkg::lcv_state_t st_q, st_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic [8:0] steps_q, steps_d;
    logic [23:0] acc_bb_q, acc_bb_d;
    logic [23:0] acc_ir_q, acc_ir_d;
    logic [15:0] bb_q, bb_d;
    logic [15:0] ir_q, ir_d;
    logic [3:0] pcnt_q, pcnt_d;
    logic pend_q, pend_d;
    logic integ_q, integ_d;
    logic thr_evt, done_evt;
    // Shared combinational terms
    logic [6:0] gain_mul;
    logic [3:0] pers_need;
    logic [8:0] steps_load;
    logic enable;

    lcv_thr_if thr ();

    // Saturate a wide accumulator to a result word
    function automatic logic [15:0] sat_res(input logic [23:0] acc);
        logic [23:0] lim;
        lim = {8'h00, lcv_pkg::RES_MAX};
        sat_res = (acc > lim) ? lcv_pkg::RES_MAX : acc[15:0];
    endfunction

    // Add one step of charge, sticking at full scale
    function automatic logic [23:0] acc_add(input logic [23:0] acc, input logic [15:0] lvl,
                                            input logic [6:0] mul);
        logic [24:0] sum;
        logic [22:0] prod;
        prod = 23'(lvl * mul);
        sum = {1'b0, acc} + {2'b00, prod};
        acc_add = sum[24] ? 24'hFF_FFFF : sum[23:0];
    endfunction

    // ----------------------------------------------------------------
    // Settings decode
    // ----------------------------------------------------------------
    always_comb
    begin
        enable = ctrl_q[lcv_pkg::CTRL_EN_BIT];
        // [R11] Gain for both channels
        case (ctrl_q[lcv_pkg::CTRL_GAIN_LSB +: 2])
            lcv_pkg::GAIN_1X: gain_mul = lcv_pkg::MUL_1X;
            lcv_pkg::GAIN_8X: gain_mul = lcv_pkg::MUL_8X;
            lcv_pkg::GAIN_16X: gain_mul = lcv_pkg::MUL_16X;
            default: gain_mul = lcv_pkg::MUL_111X;
        endcase
        // [R14] Steps from integration count
        steps_load = lcv_pkg::STEPS_FULL - {1'b0, itime_q};
        // Zero persistence behaves as one excursion
        pers_need = (pers_q == 4'h0) ? 4'h1 : pers_q;
    end

    // Comparator on the broadband result, fed in the transfer cycle
    assign thr.result = sat_res(acc_bb_q);
    assign thr.lo = lo_q;
    assign thr.hi = hi_q;
    assign thr.valid = (st_q == lcv_pkg::LCV_XFER);

    lcv_window_check u_win
    (
        .thr(thr.chk)
    );

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        div_d = div_q;
        steps_d = steps_q;
        acc_bb_d = acc_bb_q;
        acc_ir_d = acc_ir_q;
        bb_d = bb_q;
        ir_d = ir_q;
        pcnt_d = pcnt_q;
        pend_d = pend_q;
        thr_evt = 1'b0;
        done_evt = 1'b0;
        case (st_q)
            lcv_pkg::LCV_IDLE:
            begin
                // Start fresh on enable
                if (enable)
                begin
                    st_d = lcv_pkg::LCV_INTEG;
                    div_d = '0;
                    steps_d = steps_load;
                    acc_bb_d = '0;
                    acc_ir_d = '0;
                end
            end
            lcv_pkg::LCV_INTEG:
            begin
                if (!enable)
                begin
                    st_d = lcv_pkg::LCV_IDLE;
                end
                else if (div_q == DIV_LAST)
                begin
                    div_d = '0;
                    // [R1] Both channels step together
                    acc_bb_d = acc_add(acc_bb_q, i_bb_level, gain_mul);
                    acc_ir_d = acc_add(acc_ir_q, i_ir_level, gain_mul);
                    if (steps_q == 9'h001)
                    begin
                        st_d = lcv_pkg::LCV_XFER;
                    end
                    else
                    begin
                        steps_d = steps_q - 9'h001;
                    end
                end
                else
                begin
                    div_d = div_q + DIV_W'(1);
                end
            end
            lcv_pkg::LCV_XFER:
            begin
                // [R2] Load per-channel data registers
                // [R3] Both words change in one edge
                bb_d = sat_res(acc_bb_q);
                ir_d = sat_res(acc_ir_q);
                done_evt = 1'b1;
                // [R7] Count consecutive excursions
                if (thr.outside)
                begin
                    if (pcnt_q + 4'h1 >= pers_need)
                    begin
                        // [R6] Window excursion raises condition
                        thr_evt = 1'b1;
                        pend_d = 1'b1;
                    end
                    else
                    begin
                        pcnt_d = pcnt_q + 4'h1;
                    end
                end
                else
                begin
                    pcnt_d = 4'h0;
                end
                // [R4] Restart integration unprompted
                st_d = enable ? lcv_pkg::LCV_INTEG : lcv_pkg::LCV_IDLE;
                div_d = '0;
                steps_d = steps_load;
                acc_bb_d = '0;
                acc_ir_d = '0;
            end
            default:
            begin
                st_d = lcv_pkg::LCV_IDLE;
            end
        endcase
        // [R15] Clear releases line and re-arms count; a new excursion wins
        if (clr_pulse)
        begin
            pcnt_d = 4'h0;
            pend_d = thr_evt;
        end
        integ_d = (st_d == lcv_pkg::LCV_INTEG);
    end

    // Sequencer registers
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st_q <= lcv_pkg::LCV_IDLE;
            div_q <= '0;
            steps_q <= '0;
            acc_bb_q <= '0;
            acc_ir_q <= '0;
            bb_q <= '0;
            ir_q <= '0;
            pcnt_q <= '0;
            pend_q <= 1'b0;
            integ_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            div_q <= div_d;
            steps_q <= steps_d;
            acc_bb_q <= acc_bb_d;
            acc_ir_q <= acc_ir_d;
            bb_q <= bb_d;
            ir_q <= ir_d;
            // [R8] Pending holds until cleared
            pcnt_q <= pcnt_d;
            pend_q <= pend_d;
            integ_q <= integ_d;
        end
    end

    // ----------------------------------------------------------------
    // Register slave
    // ----------------------------------------------------------------
    always_comb
    begin
        logic hit;
        logic wr;
        logic rd;
        logic [7:0] adr;
        logic [31:0] wm;
        logic [31:0] wv;
        hit = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        adr = {i_wb_adr[7:2], 2'b00};
        wm = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
        wv = i_wb_dat & wm;
        // [R10] Register target answers each access once
        hit = i_wb_cyc && i_wb_stb && !ack_q;
        wr = hit && i_wb_we;
        rd = hit && !i_wb_we;
        ack_d = hit;
        rdat_d = rdat_q;
        ctrl_d = ctrl_q;
        itime_d = itime_q;
        lo_d = lo_q;
        hi_d = hi_q;
        pers_d = pers_q;
        mask_d = mask_q;
        sts_d = sts_q;
        taddr_d = taddr_q;
        strap_d = 1'b1;
        clr_pulse = 1'b0;
        // [R12] Catch address pin once after reset
        if (!strap_q)
        begin
            // [R13] Level to target address
            case (i_addr_sel)
                lcv_pkg::ASEL_GND: taddr_d = lcv_pkg::TADDR_GND;
                lcv_pkg::ASEL_FLOAT: taddr_d = lcv_pkg::TADDR_FLOAT;
                default: taddr_d = lcv_pkg::TADDR_VDD;
            endcase
        end
        // Byte-lane writes; read-only offsets ignore writes
        if (wr)
        begin
            case (adr)
                lcv_pkg::OFS_CTRL: ctrl_d = (ctrl_q & ~wm[2:0]) | wv[2:0];
                lcv_pkg::OFS_ITIME: itime_d = (itime_q & ~wm[7:0]) | wv[7:0];
                // [R5] Window limits programmed
                lcv_pkg::OFS_THR_LO: lo_d = (lo_q & ~wm[15:0]) | wv[15:0];
                lcv_pkg::OFS_THR_HI: hi_d = (hi_q & ~wm[15:0]) | wv[15:0];
                lcv_pkg::OFS_PERS: pers_d = (pers_q & ~wm[3:0]) | wv[3:0];
                lcv_pkg::OFS_MASK: mask_d = (mask_q & ~wm[1:0]) | wv[1:0];
                // [R15] Dedicated clear write
                lcv_pkg::OFS_INT_CLR: clr_pulse = 1'b1;
                default: clr_pulse = 1'b0;
            endcase
        end
        // Read mux; unmapped offsets read zero
        if (rd)
        begin
            case (adr)
                lcv_pkg::OFS_CTRL: rdat_d = {29'h0, ctrl_q};
                lcv_pkg::OFS_ITIME: rdat_d = {24'h00_0000, itime_q};
                lcv_pkg::OFS_THR_LO: rdat_d = {16'h0000, lo_q};
                lcv_pkg::OFS_THR_HI: rdat_d = {16'h0000, hi_q};
                lcv_pkg::OFS_PERS: rdat_d = {28'h000_0000, pers_q};
                lcv_pkg::OFS_BB: rdat_d = {16'h0000, bb_q};
                lcv_pkg::OFS_IR: rdat_d = {16'h0000, ir_q};
                // Both channels of one cycle in one word
                lcv_pkg::OFS_BOTH: rdat_d = {ir_q, bb_q};
                lcv_pkg::OFS_STATUS: rdat_d = {30'h0, sts_q};
                lcv_pkg::OFS_MASK: rdat_d = {30'h0, mask_q};
                lcv_pkg::OFS_TADDR: rdat_d = {25'h0, taddr_q};
                lcv_pkg::OFS_INFO: rdat_d = {30'h0, integ_q, pend_q};
                default: rdat_d = 32'h0000_0000;
            endcase
            // Status clears on read
            if (adr == lcv_pkg::OFS_STATUS)
            begin
                sts_d = '0;
            end
        end
        // Events set after clear so a same-cycle event survives
        if (thr_evt)
        begin
            sts_d[lcv_pkg::STS_THR_BIT] = 1'b1;
        end
        if (done_evt)
        begin
            sts_d[lcv_pkg::STS_DONE_BIT] = 1'b1;
        end
        irq_d = |(sts_d & mask_d);
    end

    // Register bank
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ack_q <= 1'b0;
            rdat_q <= '0;
            ctrl_q <= lcv_pkg::CTRL_RST;
            itime_q <= lcv_pkg::ITIME_RST;
            lo_q <= lcv_pkg::THR_LO_RST;
            hi_q <= lcv_pkg::THR_HI_RST;
            pers_q <= lcv_pkg::PERS_RST;
            mask_q <= lcv_pkg::MASK_RST;
            sts_q <= '0;
            irq_q <= 1'b0;
            taddr_q <= '0;
            strap_q <= 1'b0;
        end
        else
        begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            ctrl_q <= ctrl_d;
            itime_q <= itime_d;
            lo_q <= lo_d;
            hi_q <= hi_d;
            pers_q <= pers_d;
            mask_q <= mask_d;
            sts_q <= sts_d;
            irq_q <= irq_d;
            taddr_q <= taddr_d;
            strap_q <= strap_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;
    assign o_irq = irq_q;
    assign o_integrating = integ_q;
    // [R9] Open drain: only ever drives low
    assign o_int_n_o = 1'b0;
    assign o_int_n_oe = pend_q;
endmodule

// [dv/lcv_chk.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checks for the conversion block
// ----------------------------------------------------------------
module lcv_chk
#(
    parameter int unsigned STEP_CYCLES = 4
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic o_integrating,
    input wire logic o_int_n_o,
    input wire logic o_int_n_oe,
    input wire logic o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic take; // Request taken at this edge
    logic clr_wr; // Interrupt clear write
    logic ctl_wr; // Control write, may abort a run
    logic [31:0] run_q, run_d; // Length of the integrating run
    assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign clr_wr = take && i_wb_we && (i_wb_adr == lcv_pkg::OFS_INT_CLR);
    assign ctl_wr = take && i_wb_we && (i_wb_adr == lcv_pkg::OFS_CTRL);
    // Run counter, cleared whenever integration pauses
    assign run_d = o_integrating ? run_q + 32'h0000_0001 : 32'h0000_0000;
    always_ff @(posedge i_clk)
    begin
        run_q <= i_rst ? 32'h0000_0000 : run_d;
    end
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (take |=> o_wb_ack)
        else $error("request not answered next cycle");
    ack_source_a: assert property ($rose(o_wb_ack) |-> $past(take))
        else $error("ack without request");
    dat_hold_a: assert property (!$past(take && !i_wb_we) |-> $stable(o_wb_dat))
        else $error("read data moved without read");
    pin_low_a: assert property (o_int_n_oe |-> o_int_n_o == 1'b0)
        else $error("pin driven high");
    pend_hold_a: assert property ($fell(o_int_n_oe) |-> $past(clr_wr) || $past(clr_wr, 2))
        else $error("pending dropped without clear");
    pend_xfer_a: assert property ($rose(o_int_n_oe)
        |-> !$past(o_integrating) || !$past(o_integrating, 2))
        else $error("pending outside transfer");
    run_len_a: assert property ($fell(o_integrating) && !$past(ctl_wr)
        && !$past(ctl_wr, 2) |-> run_q != 0 && run_q % STEP_CYCLES == 0)
        else $error("run not whole steps");
    auto_next_a: assert property ($fell(o_integrating) && !$past(ctl_wr)
        && !$past(ctl_wr, 2) |=> o_integrating)
        else $error("next cycle not started");
    cover property ($rose(o_int_n_oe));
    cover property ($rose(o_irq));
    cover property ($fell(o_integrating) ##1 o_integrating);
endmodule

// [dv/lcv_host_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host side: bus master and pulled-up interrupt pin
// ----------------------------------------------------------------
module lcv_host_model
(
    input wire logic i_clk,
    input wire logic i_wb_ack,
    input wire logic i_int_n_o,
    input wire logic i_int_n_oe,
    output logic o_wb_cyc,
    output logic o_wb_stb,
    output logic o_wb_we,
    output logic [7:0] o_wb_adr,
    output logic [31:0] o_wb_dat,
    output logic [3:0] o_wb_sel,
    output logic o_int_n
);
    assign o_int_n = i_int_n_oe ? i_int_n_o : 1'b1;
    initial
    begin
        o_wb_cyc = 1'b0;
        o_wb_stb = 1'b0;
        o_wb_we = 1'b0;
        o_wb_adr = 8'h00;
        o_wb_dat = 32'h0000_0000;
        o_wb_sel = 4'h0;
    end
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        o_wb_cyc <= 1'b1;
        o_wb_stb <= 1'b1;
        o_wb_we <= we;
        o_wb_adr <= adr;
        o_wb_dat <= dat;
        o_wb_sel <= 4'hF;
        @(posedge i_clk);
        while (i_wb_ack !== 1'b1)
            @(posedge i_clk);
        // Released address and data lines do not keep the old value
        o_wb_cyc <= 1'b0;
        o_wb_stb <= 1'b0;
        o_wb_adr <= ~adr;
        o_wb_dat <= ~dat;
        @(posedge i_clk);
    endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned STEPS = 4; // Short step for simulation
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic wb_cyc, wb_stb, wb_we, wb_ack, integ, od_o, od_oe, irq, int_n;
    logic [7:0] wb_adr;
    logic [31:0] wb_wdat, wb_rdat;
    logic [3:0] wb_sel;
    logic [1:0] asel = 2'h0;
    logic [15:0] bb = 16'h0000;
    logic [15:0] ir = 16'h0000;
    int num_errors = 0;
    int comparisons = 0;
    logic [31:0] exp_q[$]; // Expected read data, oldest first
    always #10 i_clk = ~i_clk;
    lcv_top #(.STEP_CYCLES(STEPS)) i_lcv_top (.i_clk(i_clk), .i_rst(i_rst),
        .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
        .i_wb_dat(wb_wdat), .i_wb_sel(wb_sel), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack),
        .i_addr_sel(asel), .i_bb_level(bb), .i_ir_level(ir), .o_integrating(integ),
        .o_int_n_o(od_o), .o_int_n_oe(od_oe), .o_irq(irq));
    lcv_host_model i_lcv_host_model (.i_clk(i_clk), .i_wb_ack(wb_ack), .i_int_n_o(od_o),
        .i_int_n_oe(od_oe), .o_wb_cyc(wb_cyc), .o_wb_stb(wb_stb), .o_wb_we(wb_we),
        .o_wb_adr(wb_adr), .o_wb_dat(wb_wdat), .o_wb_sel(wb_sel), .o_int_n(int_n));
    task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e)
        begin
            $display("Error %s expected %h seen %h", name, e, s);
            num_errors++;
        end
    endtask
    // Read monitor, compares data at the acknowledging edge
    always @(posedge i_clk)
        if (wb_ack === 1'b1 && wb_cyc && !wb_we)
            check("read", exp_q.pop_front(), wb_rdat);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_lcv_host_model.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        i_lcv_host_model.xfer(1'b0, a, 32'h0000_0000);
    endtask
    task automatic rst(input logic [1:0] s);
        i_rst <= 1'b1;
        asel <= s;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask
    // Count transfers until the pin goes pending
    task automatic count_pend(output int n);
        logic pv;
        n = 0;
        pv = 1'b0;
        for (int k = 0; k < 300 && od_oe !== 1'b1; k++)
        begin
            @(posedge i_clk);
            if (pv && integ === 1'b0)
                n++;
            pv = integ;
        end
    endtask
    function automatic logic [15:0] sat(input logic [15:0] l, input logic [6:0] m);
        logic [31:0] p;
        p = 32'(l) * 32'(m) * 32'h0000_0002;
        return (p > 32'h0000_FFFF) ? 16'hFFFF : p[15:0];
    endfunction
    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        final_report();
    end
    initial
    begin
        logic [7:0] ra[7];
        logic [31:0] re[7];
        logic [6:0] mt[4];
        logic [15:0] bv, iv;
        logic [1:0] g;
        int n;
        ra = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h24, 8'h20};
        re = '{32'h0, 32'hFF, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0};
        mt = '{7'h01, 7'h08, 7'h10, 7'h6F};
        n = $urandom(39629);
        // Address pin levels, read-only and reset values
        for (int s = 0; s < 4; s++)
        begin
            rst(2'(s));
            wr(lcv_pkg::OFS_TADDR, 32'h0000_0000);
            rd(lcv_pkg::OFS_TADDR, (s == 0) ? 32'h29 : (s == 1) ? 32'h39 : 32'h49);
        end
        foreach (ra[i])
            rd(ra[i], re[i]);
        rd(8'h3C, 32'h0000_0000);
        $display("Test reset done");
        // Two-step conversion with random gain and light
        rst(2'h0);
        g = 2'($urandom);
        bv = 16'($urandom) & 16'h3FFF;
        iv = 16'($urandom) & 16'h3FFF;
        bb <= bv;
        ir <= iv;
        wr(lcv_pkg::OFS_ITIME, 32'h0000_00FE);
        wr(lcv_pkg::OFS_MASK, 32'h0000_0002);
        wr(lcv_pkg::OFS_CTRL, {29'h0, g, 1'b1});
        for (int k = 0; k < 200 && irq !== 1'b1; k++)
            @(posedge i_clk);
        check("irq", 1, irq);
        check("integrating", 1, integ);
        wr(lcv_pkg::OFS_CTRL, 32'h0000_0000);
        rd(lcv_pkg::OFS_BOTH, {sat(iv, mt[g]), sat(bv, mt[g])});
        rd(lcv_pkg::OFS_BB, {16'h0, sat(bv, mt[g])});
        rd(lcv_pkg::OFS_IR, {16'h0, sat(iv, mt[g])});
        rd(lcv_pkg::OFS_STATUS, 32'h0000_0002);
        rd(lcv_pkg::OFS_STATUS, 32'h0000_0000);
        check("irq", 0, irq);
        $display("Test conversion done");
        // Upper then lower excursion with persistence three
        rst(2'h0);
        bb <= 16'h0100;
        ir <= 16'h0010;
        wr(lcv_pkg::OFS_THR_HI, 32'h0000_0010);
        wr(lcv_pkg::OFS_PERS, 32'h0000_0003);
        wr(lcv_pkg::OFS_MASK, 32'h0000_0001);
        wr(lcv_pkg::OFS_CTRL, 32'h0000_0001);
        count_pend(n);
        check("persist", 3, n);
        check("pin", 0, int_n);
        wr(lcv_pkg::OFS_THR_HI, 32'h0000_FFFF);
        repeat (20) @(posedge i_clk);
        check("hold", 1, od_oe);
        check("irq", 1, irq);
        wr(lcv_pkg::OFS_CTRL, 32'h0000_0000);
        rd(lcv_pkg::OFS_INFO, 32'h0000_0001);
        wr(lcv_pkg::OFS_INT_CLR, 32'h0000_0001);
        check("clear", 1, int_n);
        wr(lcv_pkg::OFS_THR_LO, 32'h0000_0200);
        rd(lcv_pkg::OFS_STATUS, 32'h0000_0003);
        check("irq", 0, irq);
        wr(lcv_pkg::OFS_CTRL, 32'h0000_0001);
        count_pend(n);
        check("rearm", 3, n);
        check("pin", 0, int_n);
        $display("Test threshold done");
        final_report();
    end
endmodule
bind lcv_top lcv_chk #(.STEP_CYCLES(STEP_CYCLES)) i_lcv_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_integrating(o_integrating),
    .o_int_n_o(o_int_n_o), .o_int_n_oe(o_int_n_oe), .o_irq(o_irq));
